// >>> common/ext_bus_pkg.sv
package ext_bus_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_START    = 3'b001,
    ST_WAIT     = 3'b010,
    ST_RECOVER  = 3'b011,
    ST_INTERNAL = 3'b100
  } bus_state_type;

  // port width code, also the level read from the transfer-size pins at reset
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_8 = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_RESET = WIDTH_32;

  // access size code, driven on the transfer-size pins during a cycle
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // target of a request, decoded upstream
  localparam logic [1:0] TGT_EXT_SRAM = 2'h0;
  localparam logic [1:0] TGT_SDRAM = 2'h1;
  localparam logic [1:0] TGT_ONCHIP_PERIPH = 2'h2;
  localparam logic [1:0] TGT_ONCHIP_MEM = 2'h3;

  localparam int ADDR_PINS = 24;
  localparam int DATA_PINS = 16;
  localparam int CHIP_SELECTS = 8;
  localparam int BOOT_CS = 0;
  localparam int SYNC_STAGES = 2;
  // cycles after reset release before the transfer-size pins are sampled
  localparam logic [1:0] STRAP_CYCLES = 2'h3;

  localparam logic [1:0] LANES_UPPER = 2'h2;
  localparam logic [1:0] LANES_LOWER = 2'h1;
  localparam logic [1:0] LANES_BOTH = 2'h3;
  localparam logic [1:0] LANES_NONE = 2'h0;

endpackage

// >>> core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);

  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  assign synced = sync_q;

endmodule

`default_nettype wire

// >>> core/ext_bus_cycle.sv
// Summary of operation
// - during external sram and peripheral cycles a byte-lane strobe is driven low for each byte to move.
// - only the byte lanes the current access uses get a strobe, the others stay negated.
// - strobe bit 1 serves the most significant data lane and bit 0 the least significant lane.
// - on-chip peripheral accesses also assert strobes, on-chip memory accesses never do.
// - during sdram cycles the strobes act as column strobes where high marks a transferred byte.
// - output enable is asserted only during external sram read cycles.
// - the slave acknowledges completion and on a read the data bus is captured at that acknowledge.
// - on a write the cycle ends as soon as the acknowledge is recognised.
// - an error acknowledge ends the cycle and raises an access error toward the core.
// - direction is high for reads and low for writes, and the sdram write strobe carries it for sdram.
// - each chip select has its own port width code of 8, 16 or 32 bits; 16 and 32 both move 16 bits per beat, with accesses split to fit.
// - the boot chip select width comes from the transfer-size pins at reset, which then become outputs.
// - transfer start marks the first cycle of each beat and transfer in progress covers each beat, negating between beats.
// - the low 24 address bits appear on the address pins.
`timescale 1ns/1ps
`default_nettype none

module ext_bus_cycle #(
  parameter int CS_COUNT = ext_bus_pkg::CHIP_SELECTS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [1:0] req_size,
  input wire logic [1:0] req_target,
  input wire logic [$clog2(CS_COUNT)-1:0] req_cs,
  input wire logic [31:0] req_wdata,
  output logic busy,
  output logic done,
  output logic access_error,
  output logic [31:0] rdata,
  input wire logic width_cfg_wr,
  input wire logic [$clog2(CS_COUNT)-1:0] width_cfg_cs,
  input wire logic [1:0] width_cfg_val,
  output logic [ext_bus_pkg::ADDR_PINS-1:0] addr_pins,
  input wire logic [ext_bus_pkg::DATA_PINS-1:0] data_pins_in,
  output logic [ext_bus_pkg::DATA_PINS-1:0] data_pins_out,
  output logic data_pins_oe,
  output logic [1:0] byte_lane_strobe_n,
  output logic output_enable_n,
  output logic read_write,
  output logic sdram_write_strobe_n,
  output logic transfer_begin_n,
  output logic transfer_ongoing_n,
  input wire logic transfer_ack_n,
  input wire logic bus_error_ack_n,
  input wire logic [1:0] access_width_pins_in,
  output logic [1:0] access_width_pins_out,
  output logic access_width_pins_oe
);

  localparam int CSW = $clog2(CS_COUNT);

  function automatic logic [2:0] beat_count(input logic [1:0] size, input logic narrow);
    if (size == ext_bus_pkg::SIZE_BYTE) begin
      beat_count = 3'h1;
    end else if (size == ext_bus_pkg::SIZE_WORD) begin
      beat_count = narrow ? 3'h2 : 3'h1;
    end else begin
      beat_count = narrow ? 3'h4 : 3'h2;
    end
  endfunction

  function automatic logic [1:0] lane_mask(input logic byte_chunk, input logic narrow, input logic a0);
    if (narrow) begin
      lane_mask = ext_bus_pkg::LANES_UPPER;
    end else if (byte_chunk) begin
      lane_mask = a0 ? ext_bus_pkg::LANES_LOWER : ext_bus_pkg::LANES_UPPER;
    end else begin
      lane_mask = ext_bus_pkg::LANES_BOTH;
    end
  endfunction

  ext_bus_pkg::bus_state_type state_q, state_d;
  logic busy_q, busy_d, done_q, done_d, err_q, err_d, fin_q, fin_d;
  logic write_q, write_d;
  logic [1:0] size_q, size_d, target_q, target_d;
  logic [CSW-1:0] cs_q, cs_d;
  logic [31:0] addr_q, addr_d, wsh_q, wsh_d, rsh_q, rsh_d, rdata_q, rdata_d;
  logic [2:0] beat_q, beat_d;
  logic [1:0] width_q [CS_COUNT];
  logic [1:0] strap_cnt_q;
  logic strap_done_q;

  logic [ext_bus_pkg::ADDR_PINS-1:0] addr_pins_q;
  logic [ext_bus_pkg::DATA_PINS-1:0] dout_q;
  logic doe_q, oe_n_q, rw_q, sdwe_n_q, ts_n_q, tip_n_q, awp_oe_q;
  logic [1:0] strobe_n_q, awp_q;

  // ack, error ack, width straps and data all cross through the same two stages
  logic ack_n_s, err_n_s;
  logic [1:0] straps_s;
  logic [ext_bus_pkg::DATA_PINS-1:0] din_s;

  pin_sync #(
    .WIDTH(ext_bus_pkg::DATA_PINS + 4),
    .INIT({2'h3, 2'h0, 16'h0000})
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pins({transfer_ack_n, bus_error_ack_n, access_width_pins_in, data_pins_in}),
    .synced({ack_n_s, err_n_s, straps_s, din_s})
  );

  // decode of the request being issued and of the cycle in flight
  wire accept = req_valid && !busy_q;
  wire narrow_q = (width_q[cs_q] == ext_bus_pkg::WIDTH_8);
  wire chunk_byte_q = narrow_q || (size_q == ext_bus_pkg::SIZE_BYTE);
  wire last_beat = (beat_q == beat_count(size_q, narrow_q) - 3'h1);
  wire ack_seen = !ack_n_s;
  wire err_seen = !err_n_s;
  wire quiet = ack_n_s && err_n_s;
  wire [7:0] rbyte = (!narrow_q && addr_q[0]) ? din_s[7:0] : din_s[15:8];
  wire [31:0] rsh_next = chunk_byte_q ? {rsh_q[23:0], rbyte} : {rsh_q[15:0], din_s};
  wire [31:0] wsh_next = chunk_byte_q ? {wsh_q[23:0], 8'h00} : {wsh_q[15:0], 16'h0000};
  wire [31:0] addr_next = addr_q + (chunk_byte_q ? 32'h1 : 32'h2);
  wire [31:0] wsh_load = (req_size == ext_bus_pkg::SIZE_BYTE) ? {req_wdata[7:0], 24'h0} :
                         (req_size == ext_bus_pkg::SIZE_WORD) ? {req_wdata[15:0], 16'h0} : req_wdata;

  always_comb begin
    state_d = state_q;
    busy_d = busy_q;
    done_d = 1'b0;
    err_d = 1'b0;
    fin_d = fin_q;
    write_d = write_q;
    size_d = size_q;
    target_d = target_q;
    cs_d = cs_q;
    addr_d = addr_q;
    wsh_d = wsh_q;
    rsh_d = rsh_q;
    rdata_d = rdata_q;
    beat_d = beat_q;
    case (state_q)
      ext_bus_pkg::ST_IDLE: begin
        busy_d = 1'b0;
        if (accept) begin
          write_d = req_write;
          size_d = req_size;
          target_d = req_target;
          cs_d = req_cs;
          addr_d = req_addr;
          wsh_d = wsh_load;
          rsh_d = 32'h0;
          beat_d = 3'h0;
          fin_d = 1'b0;
          if (req_target == ext_bus_pkg::TGT_ONCHIP_MEM) begin
            done_d = 1'b1;
          end else if (req_target == ext_bus_pkg::TGT_ONCHIP_PERIPH) begin
            busy_d = 1'b1;
            state_d = ext_bus_pkg::ST_INTERNAL;
          end else begin
            busy_d = 1'b1;
            state_d = ext_bus_pkg::ST_START;
          end
        end
      end
      ext_bus_pkg::ST_START: begin
        state_d = ext_bus_pkg::ST_WAIT;
      end
      ext_bus_pkg::ST_WAIT: begin
        // error ack wins over a simultaneous ack and drops the remaining beats
        if (err_seen) begin
          err_d = 1'b1;
          fin_d = 1'b1;
          state_d = ext_bus_pkg::ST_RECOVER;
        end else if (ack_seen) begin
          rsh_d = write_q ? rsh_q : rsh_next;
          wsh_d = wsh_next;
          addr_d = addr_next;
          beat_d = beat_q + 3'h1;
          state_d = ext_bus_pkg::ST_RECOVER;
          if (last_beat) begin
            fin_d = 1'b1;
            done_d = 1'b1;
            rdata_d = write_q ? rdata_q : rsh_next;
          end
        end
      end
      ext_bus_pkg::ST_RECOVER: begin
        // the synchronised ack lags the pin, so wait for it to clear before the next beat
        if (quiet) begin
          state_d = fin_q ? ext_bus_pkg::ST_IDLE : ext_bus_pkg::ST_START;
          busy_d = !fin_q;
        end
      end
      ext_bus_pkg::ST_INTERNAL: begin
        done_d = 1'b1;
        busy_d = 1'b0;
        state_d = ext_bus_pkg::ST_IDLE;
      end
      default: begin
        state_d = ext_bus_pkg::ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // pin values follow the next state so every pin comes from a flip-flop
  wire pins_on = (state_d == ext_bus_pkg::ST_START) || (state_d == ext_bus_pkg::ST_WAIT);
  wire narrow_d = (width_q[cs_d] == ext_bus_pkg::WIDTH_8);
  wire chunk_byte_d = narrow_d || (size_d == ext_bus_pkg::SIZE_BYTE);
  wire [1:0] lanes_d = lane_mask(chunk_byte_d, narrow_d, addr_d[0]);
  wire is_sdram = (target_d == ext_bus_pkg::TGT_SDRAM);
  wire is_sram = (target_d == ext_bus_pkg::TGT_EXT_SRAM);
  wire is_periph = (state_d == ext_bus_pkg::ST_INTERNAL);
  wire [1:0] strobe_n_d = (pins_on && is_sdram) ? ~(~lanes_d) :
                          ((pins_on && is_sram) || is_periph) ? ~lanes_d :
                          2'h3;
  wire [15:0] dout_d = chunk_byte_d ? {wsh_d[31:24], wsh_d[31:24]} : wsh_d[31:16];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ext_bus_pkg::ST_IDLE;
      busy_q <= 1'b1;
      done_q <= 1'b0;
      err_q <= 1'b0;
      fin_q <= 1'b0;
      write_q <= 1'b0;
      size_q <= ext_bus_pkg::SIZE_LONG;
      target_q <= ext_bus_pkg::TGT_EXT_SRAM;
      cs_q <= '0;
      addr_q <= 32'h0;
      wsh_q <= 32'h0;
      rsh_q <= 32'h0;
      rdata_q <= 32'h0;
      beat_q <= 3'h0;
    end else begin
      state_q <= state_d;
      // busy holds through the strap window
      busy_q <= strap_done_q ? busy_d : 1'b1;
      done_q <= done_d;
      err_q <= err_d;
      fin_q <= fin_d;
      write_q <= write_d;
      size_q <= size_d;
      target_q <= target_d;
      cs_q <= cs_d;
      addr_q <= addr_d;
      wsh_q <= wsh_d;
      rsh_q <= rsh_d;
      rdata_q <= rdata_d;
      beat_q <= beat_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      for (int i = 0; i < CS_COUNT; i++) begin
        width_q[i] <= ext_bus_pkg::WIDTH_RESET;
      end
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == ext_bus_pkg::STRAP_CYCLES - 2'h1) begin
        strap_done_q <= 1'b1;
        width_q[ext_bus_pkg::BOOT_CS] <= straps_s;
      end
    end else if (width_cfg_wr) begin
      width_q[width_cfg_cs] <= width_cfg_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_pins_q <= '0;
      dout_q <= '0;
      doe_q <= 1'b0;
      strobe_n_q <= 2'h3;
      oe_n_q <= 1'b1;
      rw_q <= 1'b1;
      sdwe_n_q <= 1'b1;
      ts_n_q <= 1'b1;
      tip_n_q <= 1'b1;
      awp_q <= 2'h0;
      awp_oe_q <= 1'b0;
    end else begin
      addr_pins_q <= addr_d[ext_bus_pkg::ADDR_PINS-1:0];
      dout_q <= dout_d;
      doe_q <= pins_on && write_d;
      strobe_n_q <= strobe_n_d;
      oe_n_q <= !(pins_on && is_sram && !write_d);
      rw_q <= !(pins_on && write_d);
      sdwe_n_q <= !(pins_on && is_sdram && write_d);
      ts_n_q <= (state_d != ext_bus_pkg::ST_START);
      tip_n_q <= !pins_on;
      awp_q <= pins_on ? size_d : 2'h0;
      awp_oe_q <= strap_done_q;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign access_error = err_q;
  assign rdata = rdata_q;
  assign addr_pins = addr_pins_q;
  assign data_pins_out = dout_q;
  assign data_pins_oe = doe_q;
  assign byte_lane_strobe_n = strobe_n_q;
  assign output_enable_n = oe_n_q;
  assign read_write = rw_q;
  assign sdram_write_strobe_n = sdwe_n_q;
  assign transfer_begin_n = ts_n_q;
  assign transfer_ongoing_n = tip_n_q;
  assign access_width_pins_out = awp_q;
  assign access_width_pins_oe = awp_oe_q;

endmodule

`default_nettype wire

// >>> testbench/ext_bus_cycle_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_cycle_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic done,
  input wire logic access_error,
  input wire logic [ext_bus_pkg::ADDR_PINS-1:0] addr_pins,
  input wire logic [1:0] byte_lane_strobe_n,
  input wire logic output_enable_n,
  input wire logic read_write,
  input wire logic sdram_write_strobe_n,
  input wire logic transfer_begin_n,
  input wire logic transfer_ongoing_n,
  input wire logic transfer_ack_n,
  input wire logic bus_error_ack_n,
  input wire logic access_width_pins_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_read_only: assert property (!output_enable_n |-> read_write && !transfer_ongoing_n)
    else $error("output enable outside a read beat");
  a_read_strobes: assert property (!output_enable_n |-> byte_lane_strobe_n != 2'h3)
    else $error("read beat without a lane strobe");
  a_sdram_dir: assert property (!sdram_write_strobe_n |-> !read_write)
    else $error("sdram write strobe with read direction");
  a_begin_pulse: assert property (!transfer_begin_n |=> transfer_begin_n && !transfer_ongoing_n)
    else $error("transfer start longer than one cycle");
  a_begin_in_beat: assert property (!transfer_begin_n |-> !transfer_ongoing_n)
    else $error("transfer start outside a beat");
  a_beat_stable: assert property ((!transfer_ongoing_n && transfer_begin_n) |->
    $stable(addr_pins) && $stable(byte_lane_strobe_n) && $stable(read_write))
    else $error("beat changed while waiting");
  a_ack_ends: assert property ((!transfer_ongoing_n && !transfer_ack_n) |-> ##[1:5] transfer_ongoing_n)
    else $error("acknowledge did not end the beat");
  a_err_ends: assert property ((!transfer_ongoing_n && !bus_error_ack_n) |-> ##[1:5] transfer_ongoing_n)
    else $error("error acknowledge did not end the beat");
  a_end_has_cause: assert property ($rose(transfer_ongoing_n) |->
    !$past(transfer_ack_n) || !$past(bus_error_ack_n))
    else $error("beat ended without acknowledge");
  a_error_no_done: assert property (access_error |-> !done && !$past(bus_error_ack_n))
    else $error("access error without cause or with done");
  a_width_pins_out: assert property (!busy |-> access_width_pins_oe)
    else $error("size pins not driven after strap");
  cover property (!transfer_begin_n && !sdram_write_strobe_n);
  cover property (!output_enable_n && transfer_begin_n);
  cover property (access_error);
endmodule
`default_nettype wire

// >>> testbench/ext_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_slave_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic fail,
  input wire logic transfer_ongoing_n,
  input wire logic output_enable_n,
  input wire logic [ext_bus_pkg::ADDR_PINS-1:0] addr_pins,
  output logic transfer_ack_n,
  output logic bus_error_ack_n,
  output logic [ext_bus_pkg::DATA_PINS-1:0] data_pins_in
);
  logic [3:0] wait_q;
  wire logic answer = wait_q >= (slow ? 4'h6 : 4'h1);
  // acknowledge is held until the beat ends so the synchroniser cannot miss it
  always_ff @(posedge clk or posedge rst) begin
    if (rst || transfer_ongoing_n) begin
      wait_q <= 4'h0;
      transfer_ack_n <= 1'b1;
      bus_error_ack_n <= 1'b1;
    end else begin
      wait_q <= answer ? wait_q : wait_q + 4'h1;
      transfer_ack_n <= !(answer && !fail);
      bus_error_ack_n <= !(answer && fail);
    end
  end
  // released bus toggles every cycle so a stale capture cannot look right
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_pins_in <= 16'h0;
    end else if (!output_enable_n) begin
      data_pins_in <= {addr_pins[7:0], ~addr_pins[7:0]};
    end else begin
      data_pins_in <= ~data_pins_in;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/ext_bus_cycle_test.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_cycle_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, width_cfg_wr = 1'b0, slow = 1'b0, fail = 1'b0;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rdata;
  logic [1:0] req_size = 2'h0, req_target = 2'h0, width_cfg_val = 2'h0, strap = ext_bus_pkg::WIDTH_RESET;
  logic [2:0] req_cs = 3'h0, width_cfg_cs = 3'h0;
  logic busy, done, access_error, data_pins_oe, output_enable_n, read_write, sdram_write_strobe_n;
  logic transfer_begin_n, transfer_ongoing_n, transfer_ack_n, bus_error_ack_n, access_width_pins_oe;
  logic [23:0] addr_pins, addr0;
  logic [15:0] data_pins_in, data_pins_out, wd0;
  logic [1:0] byte_lane_strobe_n, access_width_pins_out, strb0, awp0;
  logic oe_seen, sdwe_seen, lane_seen, rw0, doe0;
  int num_errors = 0, checks = 0, beats = 0, got_done, got_err;
  always #12.5 clk = ~clk;
  ext_bus_cycle uut (.clk, .rst, .req_valid, .req_write, .req_addr, .req_size, .req_target, .req_cs,
    .req_wdata, .busy, .done, .access_error, .rdata, .width_cfg_wr, .width_cfg_cs, .width_cfg_val,
    .addr_pins, .data_pins_in, .data_pins_out, .data_pins_oe, .byte_lane_strobe_n, .output_enable_n,
    .read_write, .sdram_write_strobe_n, .transfer_begin_n, .transfer_ongoing_n, .transfer_ack_n,
    .bus_error_ack_n, .access_width_pins_in(strap), .access_width_pins_out, .access_width_pins_oe);
  ext_slave_model slave (.clk, .rst, .slow, .fail, .transfer_ongoing_n, .output_enable_n, .addr_pins,
    .transfer_ack_n, .bus_error_ack_n, .data_pins_in);
  always @(posedge clk) begin
    if (!transfer_begin_n) begin
      beats <= beats + 1;
      if (beats == 0) begin
        {strb0, awp0, addr0, wd0, rw0, doe0} <= {byte_lane_strobe_n, access_width_pins_out, addr_pins,
          data_pins_out, read_write, data_pins_oe};
      end
    end
    if (!output_enable_n) oe_seen <= 1'b1;
    if (!sdram_write_strobe_n) sdwe_seen <= 1'b1;
    if (transfer_ongoing_n && byte_lane_strobe_n != 2'h3) lane_seen <= 1'b1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] v);
    @(posedge clk);
    rst <= 1'b1;
    strap <= v;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic set_width(input logic [2:0] cs, input logic [1:0] v);
    @(posedge clk);
    {width_cfg_wr, width_cfg_cs, width_cfg_val} <= {1'b1, cs, v};
    @(posedge clk);
    width_cfg_wr <= 1'b0;
  endtask
  task automatic access(input logic w, input logic [31:0] a, input logic [1:0] sz, input logic [1:0] tg,
    input logic [2:0] cs, input logic [31:0] wd);
    int n;
    @(negedge clk);
    {beats, oe_seen, sdwe_seen, lane_seen, got_done, got_err} = '0;
    @(posedge clk);
    {req_valid, req_write, req_addr, req_size, req_target, req_cs, req_wdata} <= {1'b1, w, a, sz, tg, cs, wd};
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    // done and error are single-cycle pulses, so look every cycle
    do begin
      @(negedge clk);
      if (done === 1'b1) got_done = 1;
      if (access_error === 1'b1) got_err = 1;
      n++;
    end while (!(got_done || got_err) && n < 300);
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check("busy", 0, busy);
  endtask
  task automatic t_read_word;
    access(1'b0, 32'h12345676, ext_bus_pkg::SIZE_WORD, ext_bus_pkg::TGT_EXT_SRAM, 3'h0, 32'h0);
    check("done", 1, got_done);
    check("rdata", 32'h00007689, rdata);
    check("strobes", 2'h0, strb0);
    check("oe", 1, oe_seen);
    check("direction", 1, rw0);
    check("data oe", 0, doe0);
    check("addr", 24'h345676, addr0);
    check("size pins", ext_bus_pkg::SIZE_WORD, awp0);
    $display("test read_word finished");
  endtask
  task automatic t_write_bytes;
    slow <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      access(1'b1, 32'h101 - i, ext_bus_pkg::SIZE_BYTE, ext_bus_pkg::TGT_EXT_SRAM, 3'h0, 32'h5a);
      check("strobes", i ? 2'h1 : 2'h2, strb0);
      check("wdata", 16'h5a5a, wd0);
      check("data oe", 1, doe0);
      check("direction", 0, rw0);
      check("oe", 0, oe_seen);
      check("done", 1, got_done);
    end
    slow <= 1'b0;
    $display("test write_bytes finished");
  endtask
  task automatic t_widths;
    access(1'b0, 32'h200, ext_bus_pkg::SIZE_LONG, ext_bus_pkg::TGT_EXT_SRAM, 3'h0, 32'h0);
    check("beats", 2, beats);
    check("rdata", 32'h00ff02fd, rdata);
    set_width(3'h1, ext_bus_pkg::WIDTH_8);
    access(1'b0, 32'h200, ext_bus_pkg::SIZE_LONG, ext_bus_pkg::TGT_EXT_SRAM, 3'h1, 32'h0);
    check("beats", 4, beats);
    set_width(3'h1, ext_bus_pkg::WIDTH_16);
    access(1'b1, 32'h200, ext_bus_pkg::SIZE_LONG, ext_bus_pkg::TGT_EXT_SRAM, 3'h1, 32'h1);
    check("beats", 2, beats);
    $display("test widths finished");
  endtask
  task automatic t_sdram_onchip;
    access(1'b1, 32'h300, ext_bus_pkg::SIZE_BYTE, ext_bus_pkg::TGT_SDRAM, 3'h0, 32'h7);
    check("sdram strobes", 2'h2, strb0);
    check("sdram we", 1, sdwe_seen);
    check("oe", 0, oe_seen);
    access(1'b0, 32'h400, ext_bus_pkg::SIZE_WORD, ext_bus_pkg::TGT_ONCHIP_PERIPH, 3'h0, 32'h0);
    check("periph strobes", 1, lane_seen);
    check("periph beats", 0, beats);
    access(1'b0, 32'h404, ext_bus_pkg::SIZE_WORD, ext_bus_pkg::TGT_ONCHIP_MEM, 3'h0, 32'h0);
    check("mem strobes", 0, lane_seen);
    check("mem done", 1, got_done);
    $display("test sdram_onchip finished");
  endtask
  task automatic t_error_strap;
    fail <= 1'b1;
    access(1'b0, 32'h500, ext_bus_pkg::SIZE_WORD, ext_bus_pkg::TGT_EXT_SRAM, 3'h0, 32'h0);
    check("error", 1, got_err);
    check("done", 0, got_done);
    fail <= 1'b0;
    do_reset(ext_bus_pkg::WIDTH_8);
    access(1'b0, 32'h600, ext_bus_pkg::SIZE_WORD, ext_bus_pkg::TGT_EXT_SRAM, 3'h0, 32'h0);
    check("strap beats", 2, beats);
    $display("test error_strap finished");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("watchdog expired");
    tally_and_finish;
  end
  initial begin
    do_reset(ext_bus_pkg::WIDTH_RESET);
    t_read_word;
    t_write_bytes;
    t_widths;
    t_sdram_onchip;
    t_error_strap;
    tally_and_finish;
  end
endmodule
bind ext_bus_cycle ext_bus_cycle_assertions chk (.clk, .rst, .busy, .done, .access_error, .addr_pins,
  .byte_lane_strobe_n, .output_enable_n, .read_write, .sdram_write_strobe_n, .transfer_begin_n,
  .transfer_ongoing_n, .transfer_ack_n, .bus_error_ack_n, .access_width_pins_oe);
`default_nettype wire
